// ==== lfcie_pkg.sv ====
/*
 * constants for the string fault configuration and interrupt gate registers.
 * assumes a byte-addressed 16-bit register port supplied by the serial host logic.
 */
package lfcie_pkg;
	localparam int unsigned LFCIE_DATA_W = 16;
	localparam logic [7:0] LFCIE_OFS_STRING_FAULT_CONFIG = 8'h06;
	localparam logic [7:0] LFCIE_OFS_SUPPLY_IRQ_ENABLE = 8'h08;
	localparam logic [7:0] LFCIE_OFS_BOOST_IRQ_ENABLE = 8'h0a;
	localparam logic [15:0] LFCIE_RST_STRING_FAULT_CONFIG = 16'h0100;
	localparam logic [15:0] LFCIE_RST_SUPPLY_IRQ_ENABLE = 16'h2aaa;
	localparam logic [15:0] LFCIE_RST_BOOST_IRQ_ENABLE = 16'ha028;
	localparam int unsigned LFCIE_STRINGS = 6;
	localparam int unsigned LFCIE_POS_GROUND_DETECT = 8;
	// field write codes; bit 1 of a stored field reads back as the enable state
	localparam logic [1:0] LFCIE_CODE_DISABLE = 2'h1;
	localparam logic [1:0] LFCIE_CODE_ENABLE = 2'h3;
	localparam int unsigned LFCIE_FIELDS = 8;
	// supply register field order: 0 in_uv,1 in_ov,2 logic_uv,3 in_oc,4 cap,5 pump,6 sync,7 reserved
	// boost register field order: 0 reserved,1 ovp,2 ocp,3 freq,4 mode,5 strcfg,6 iset,7 thermal
	localparam logic [7:0] LFCIE_SUPPLY_GATED = 8'h7f;
	localparam logic [7:0] LFCIE_BOOST_GATED = 8'hfe;
endpackage

// ==== lfcie_irq_field.sv ====
/*
 * one two-bit interrupt gate field: stores a single enable bit.
 * assumes the caller decodes the register address into i_wr.
 */
module lfcie_irq_field
	import lfcie_pkg::*;
#(
	parameter bit P_RESET_ON = 1'b1
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_wr,
	input wire logic [1:0] i_wdata,
	output logic o_enabled
);
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_enabled <= P_RESET_ON;
		end else if (i_wr && i_wdata == LFCIE_CODE_ENABLE) begin
			o_enabled <= 1'b1;
		end else if (i_wr && i_wdata == LFCIE_CODE_DISABLE) begin
			o_enabled <= 1'b0;
		end
		// codes 0h and 2h fall through and keep the state
	end

	a_field_goes_on: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_wr && i_wdata == 2'h3 |=> o_enabled)
		else $error("gate field not enabled after writing 3h");
	a_field_goes_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_wr && i_wdata == 2'h1 |=> !o_enabled)
		else $error("gate field not disabled after writing 1h");
	a_field_even_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(!i_wr || !i_wdata[0]) |=> $stable(o_enabled))
		else $error("gate field changed without a 1h or 3h write");
endmodule

// ==== lfcie_regs.sv ====
/*
 * string fault configuration and supply and boost interrupt gate registers.
 * assumes the serial host logic presents one-cycle read and write strobes
 * with a byte address, synchronous to i_clk_sys.
 */
module lfcie_regs
	import lfcie_pkg::*;
#(
	parameter int unsigned P_ADDR_W = 8
) (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic [P_ADDR_W-1:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [LFCIE_DATA_W-1:0] i_reg_wdata,
	output logic [LFCIE_DATA_W-1:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output logic [LFCIE_STRINGS-1:0] o_string_short_fault_off,
	output logic o_string_ground_short_detect_on,
	output logic o_sync_clock_missing_irq_gate,
	output logic o_charge_pump_irq_gate,
	output logic o_pump_cap_missing_irq_gate,
	output logic o_input_overcurrent_irq_gate,
	output logic o_logic_supply_low_irq_gate,
	output logic o_input_overvoltage_irq_gate,
	output logic o_input_undervoltage_irq_gate,
	output logic o_thermal_shutdown_irq_gate,
	output logic o_current_resistor_short_irq_gate,
	output logic o_string_cfg_resistor_missing_irq_gate,
	output logic o_freq_resistor_missing_irq_gate,
	output logic o_mode_resistor_missing_irq_gate,
	output logic o_boost_overcurrent_irq_gate,
	output logic o_boost_overvoltage_irq_gate
);
	if (P_ADDR_W < 4 || P_ADDR_W > 8) begin : g_bad_addr
		$error("address width must lie between 4 and 8");
	end

	logic [1:0] rst_pipe;
	logic rst_n;
	logic [LFCIE_DATA_W-1:0] string_cfg;
	logic [7:0] supply_on;
	logic [7:0] boost_on;
	logic [1:0] supply_rsvd;
	logic [1:0] boost_rsvd;
	logic [LFCIE_DATA_W-1:0] supply_view;
	logic [LFCIE_DATA_W-1:0] boost_view;
	logic [7:0] addr;
	logic wr_cfg;
	logic wr_supply;
	logic wr_boost;

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe[1];

	assign addr = 8'(i_reg_addr);
	assign wr_cfg = i_reg_wr && addr == LFCIE_OFS_STRING_FAULT_CONFIG;
	assign wr_supply = i_reg_wr && addr == LFCIE_OFS_SUPPLY_IRQ_ENABLE;
	assign wr_boost = i_reg_wr && addr == LFCIE_OFS_BOOST_IRQ_ENABLE;

	// plain read/write storage; bits 7-6 are kept as written since the host owns them
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			string_cfg <= LFCIE_RST_STRING_FAULT_CONFIG;
		end else if (wr_cfg) begin
			string_cfg <= i_reg_wdata;
		end
	end
	assign o_string_short_fault_off = string_cfg[LFCIE_STRINGS-1:0];
	assign o_string_ground_short_detect_on = string_cfg[LFCIE_POS_GROUND_DETECT];

	// reserved field pairs are ordinary storage, not gates
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			supply_rsvd <= LFCIE_RST_SUPPLY_IRQ_ENABLE[15:14];
			boost_rsvd <= LFCIE_RST_BOOST_IRQ_ENABLE[1:0];
		end else begin
			if (wr_supply) begin
				supply_rsvd <= i_reg_wdata[15:14];
			end
			if (wr_boost) begin
				boost_rsvd <= i_reg_wdata[1:0];
			end
		end
	end

	for (genvar f = 0; f < LFCIE_FIELDS; f++) begin : g_field
		if (LFCIE_SUPPLY_GATED[f]) begin : g_sup
			lfcie_irq_field #(
				.P_RESET_ON(LFCIE_RST_SUPPLY_IRQ_ENABLE[2*f+1])
			) u_sup (
				.i_clk_sys(i_clk_sys),
				.i_rst_n(rst_n),
				.i_wr(wr_supply),
				.i_wdata(i_reg_wdata[2*f+1:2*f]),
				.o_enabled(supply_on[f])
			);
			assign supply_view[2*f+1:2*f] = {supply_on[f], 1'b0};
		end else begin : g_sup_rsvd
			assign supply_on[f] = 1'b0;
			assign supply_view[2*f+1:2*f] = supply_rsvd;
		end
		if (LFCIE_BOOST_GATED[f]) begin : g_bst
			lfcie_irq_field #(
				.P_RESET_ON(LFCIE_RST_BOOST_IRQ_ENABLE[2*f+1])
			) u_bst (
				.i_clk_sys(i_clk_sys),
				.i_rst_n(rst_n),
				.i_wr(wr_boost),
				.i_wdata(i_reg_wdata[2*f+1:2*f]),
				.o_enabled(boost_on[f])
			);
			assign boost_view[2*f+1:2*f] = {boost_on[f], 1'b0};
		end else begin : g_bst_rsvd
			assign boost_on[f] = 1'b0;
			assign boost_view[2*f+1:2*f] = boost_rsvd;
		end
	end

	assign o_input_undervoltage_irq_gate = supply_on[0];
	assign o_input_overvoltage_irq_gate = supply_on[1];
	assign o_logic_supply_low_irq_gate = supply_on[2];
	assign o_input_overcurrent_irq_gate = supply_on[3];
	assign o_pump_cap_missing_irq_gate = supply_on[4];
	assign o_charge_pump_irq_gate = supply_on[5];
	assign o_sync_clock_missing_irq_gate = supply_on[6];
	assign o_boost_overvoltage_irq_gate = boost_on[1];
	assign o_boost_overcurrent_irq_gate = boost_on[2];
	assign o_freq_resistor_missing_irq_gate = boost_on[3];
	assign o_mode_resistor_missing_irq_gate = boost_on[4];
	assign o_string_cfg_resistor_missing_irq_gate = boost_on[5];
	assign o_current_resistor_short_irq_gate = boost_on[6];
	assign o_thermal_shutdown_irq_gate = boost_on[7];

	// read data is registered so the host logic sees it one cycle after the strobe;
	// an unmapped address answers zero
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_reg_rdata <= 16'h0000;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd) begin
				if (addr == LFCIE_OFS_STRING_FAULT_CONFIG) begin
					o_reg_rdata <= string_cfg;
				end else if (addr == LFCIE_OFS_SUPPLY_IRQ_ENABLE) begin
					o_reg_rdata <= supply_view;
				end else if (addr == LFCIE_OFS_BOOST_IRQ_ENABLE) begin
					o_reg_rdata <= boost_view;
				end else begin
					o_reg_rdata <= 16'h0000;
				end
			end
		end
	end

	a_short_bits_follow: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		wr_cfg |=> o_string_short_fault_off == $past(i_reg_wdata[5:0]))
		else $error("string short suppress bits do not follow the write");
	a_ground_detect_follow: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		wr_cfg |=> o_string_ground_short_detect_on == $past(i_reg_wdata[8]))
		else $error("ground detect bit does not follow the write");
	a_sync_gate_read: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		i_reg_rd && !i_reg_wr && addr == 8'h08 |=>
		o_reg_rdata[13:12] == {$past(o_sync_clock_missing_irq_gate), 1'b0})
		else $error("sync clock gate field reads back wrongly");
	a_supply_read_code: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		i_reg_rd && addr == 8'h08 |=> o_reg_rvalid && o_reg_rdata[0] == 1'b0 && o_reg_rdata[2] == 1'b0
		&& o_reg_rdata[4] == 1'b0 && o_reg_rdata[6] == 1'b0 && o_reg_rdata[8] == 1'b0)
		else $error("supply gate field reads an odd code");
	a_pump_gate_on: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		wr_supply && i_reg_wdata[11:10] == 2'h3 |=> o_charge_pump_irq_gate)
		else $error("charge pump gate not enabled by 3h");
	a_uv_gate_off: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		wr_supply && i_reg_wdata[1:0] == 2'h1 |=> !o_input_undervoltage_irq_gate)
		else $error("input under-voltage gate not disabled by 1h");
	a_logic_low_hold: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		wr_supply && !i_reg_wdata[4] |=> $stable(o_logic_supply_low_irq_gate))
		else $error("logic supply gate changed on a 0h or 2h write");
	a_thermal_read: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		i_reg_rd && !i_reg_wr && addr == 8'h0a |=>
		o_reg_rdata[15:14] == {$past(o_thermal_shutdown_irq_gate), 1'b0})
		else $error("thermal gate field reads back wrongly");
	a_freq_gate_on: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		wr_boost && i_reg_wdata[7:6] == 2'h3 |=> o_freq_resistor_missing_irq_gate)
		else $error("frequency resistor gate not enabled by 3h");
endmodule

// ==== tb_top.sv ====
/*
 * self-checking bench for the string fault config and interrupt gate registers.
 * assumes lfcie_pkg and lfcie_regs are compiled first; drives the register port directly.
 */
module tb_top import lfcie_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk_sys = 1'b0;
	logic i_reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic reg_rvalid;
	logic [5:0] short_off;
	logic gnd_on;
	logic [6:0] sup_g;
	logic [6:0] bst_g;
	int miscompares = 0;
	int n_checks = 0;

	always #25 i_clk_sys = ~i_clk_sys;

	lfcie_regs dut_u (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
		.i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid),
		.o_string_short_fault_off(short_off), .o_string_ground_short_detect_on(gnd_on),
		.o_input_undervoltage_irq_gate(sup_g[0]), .o_input_overvoltage_irq_gate(sup_g[1]),
		.o_logic_supply_low_irq_gate(sup_g[2]), .o_input_overcurrent_irq_gate(sup_g[3]),
		.o_pump_cap_missing_irq_gate(sup_g[4]), .o_charge_pump_irq_gate(sup_g[5]),
		.o_sync_clock_missing_irq_gate(sup_g[6]), .o_boost_overvoltage_irq_gate(bst_g[0]),
		.o_boost_overcurrent_irq_gate(bst_g[1]), .o_freq_resistor_missing_irq_gate(bst_g[2]),
		.o_mode_resistor_missing_irq_gate(bst_g[3]), .o_string_cfg_resistor_missing_irq_gate(bst_g[4]),
		.o_current_resistor_short_irq_gate(bst_g[5]), .o_thermal_shutdown_irq_gate(bst_g[6]));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// gate state sits in the upper bit of each pair, starting at bit lo
	function automatic logic [6:0] gate_bits(input logic [15:0] v, input int lo);
		logic [6:0] g;
		for (int i = 0; i < 7; i++) begin
			g[i] = v[lo + 2 * i];
		end
		return g;
	endfunction

	task automatic do_reset();
		i_reset_n <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge i_clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read_chk(input logic [7:0] a, input logic [15:0] exp);
		@(posedge i_clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge i_clk_sys);
		reg_rd <= 1'b0;
		#1;
		check({15'h0, reg_rvalid}, 16'h0001);
		check(reg_rdata, exp);
		@(posedge i_clk_sys);
		#1;
		check({15'h0, reg_rvalid}, 16'h0000);
	endtask

	task automatic chk_all(input logic [15:0] cfg, input logic [15:0] sup, input logic [15:0] bst);
		reg_read_chk(8'h06, cfg);
		reg_read_chk(8'h08, sup);
		reg_read_chk(8'h0a, bst);
		check({10'h0, short_off}, {10'h0, cfg[5:0]});
		check({15'h0, gnd_on}, {15'h0, cfg[8]});
		check({9'h0, sup_g}, {9'h0, gate_bits(sup, 1)});
		check({9'h0, bst_g}, {9'h0, gate_bits(bst, 3)});
	endtask

	task automatic t_reset_values();
		chk_all(16'h0100, 16'h2aaa, 16'ha028);
	endtask

	// supply fields get each of the four codes, boost fields get 1h, 3h and 0h only; reserved pairs simply store
	task automatic t_gate_codes();
		reg_write(8'h08, 16'h5555);
		chk_all(16'h0100, 16'h4000, 16'ha028);
		reg_write(8'h08, 16'h0000);
		chk_all(16'h0100, 16'h0000, 16'ha028);
		reg_write(8'h08, 16'hffff);
		reg_write(8'h0a, 16'h5555);
		chk_all(16'h0100, 16'heaaa, 16'h0001);
		reg_write(8'h0a, 16'hffff);
		reg_write(8'h08, 16'haaaa);
		chk_all(16'h0100, 16'haaaa, 16'haaab);
		reg_write(8'h0a, 16'h0000);
		chk_all(16'h0100, 16'haaaa, 16'haaa8);
	endtask

	// the host keeps bits 7-6 clear in every config write
	task automatic t_config();
		reg_write(8'h06, 16'hfe15);
		chk_all(16'hfe15, 16'haaaa, 16'haaa8);
		reg_write(8'h06, 16'h012a);
		chk_all(16'h012a, 16'haaaa, 16'haaa8);
	endtask

	task automatic t_unmapped_and_collision();
		reg_write(8'h0c, 16'h5555);
		reg_read_chk(8'h0c, 16'h0000);
		@(posedge i_clk_sys);
		reg_addr <= 8'h08;
		reg_wdata <= 16'h5555;
		reg_wr <= 1'b1;
		reg_rd <= 1'b1;
		@(posedge i_clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, 16'haaaa);
		chk_all(16'h012a, 16'h4000, 16'haaa8);
	endtask

	task automatic print_verdict();
		if (miscompares == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#(3000 * 50);
		miscompares++;
		print_verdict();
	end

	initial begin
		do_reset();
		t_reset_values();
		t_gate_codes();
		t_config();
		t_unmapped_and_collision();
		do_reset();
		t_reset_values();
		print_verdict();
	end
endmodule
